// File: include/pbd_pkg.sv
// Purpose: shared constants for the packet buffer DMA block
// Assumes: 100 MHz clock, AXI4-Lite register bus
// Notes: offsets are byte addresses
package pbd_pkg;
	localparam int CLK_NS = 10;
	localparam int WAIT_MIN_NS = 100;
	localparam int WAIT_MAX_NS = 150;
	localparam int WAIT_CYC = (WAIT_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAIT_MAX_CYC = WAIT_MAX_NS / CLK_NS;
	localparam logic [4:0] WAIT_N = 5'(WAIT_CYC);
	localparam logic [10:0] MAX_FRAME = 11'h5FC;
	localparam logic [4:0] TRY_LAST = 5'h0F;
	localparam int QDEPTH = 18;
	localparam logic [10:0] DATA_OFF = 11'h002;
	localparam logic [10:0] HDR_OFF = 11'h000;
	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_PTR = 8'h04;
	localparam logic [7:0] A_DATA = 8'h08;
	localparam logic [7:0] A_PNR = 8'h0C;
	localparam logic [7:0] A_CMD = 8'h10;
	localparam logic [7:0] A_STAT = 8'h14;
	localparam logic [4:0] CTRL_RST = 5'h00;
	// Control bits
	localparam int B_ZW = 0;
	localparam int B_TXRUN = 1;
	localparam int B_RXRUN = 2;
	localparam int B_BAD = 3;
	localparam int B_AREL = 4;
	// Status bits
	localparam int S_TXQE = 16;
	localparam int S_CQNE = 17;
	localparam int S_RXQE = 18;
	localparam int S_ABORT = 19;
	localparam int S_OVRN = 20;
	// Commands
	localparam logic [2:0] C_ENQ = 3'h1;
	localparam logic [2:0] C_TXACK = 3'h2;
	localparam logic [2:0] C_RXRM = 3'h3;
	localparam logic [2:0] C_RXREL = 3'h4;
	typedef enum logic [2:0] {TX_IDLE = 3'b000, TX_RD = 3'b001,
		TX_SND = 3'b010, TX_ST = 3'b011, TX_FN = 3'b100} pbd_tx_t;
	typedef enum logic [2:0] {RX_IDLE = 3'b000, RX_AL = 3'b001,
		RX_DT = 3'b010, RX_CN = 3'b011, RX_DR = 3'b100} pbd_rx_t;
endpackage : pbd_pkg

// File: design/pbd_pnq.sv
// Purpose: 5-bit packet number queue, 18 deep
// Assumes: push and pop are one-cycle strobes
// Notes: push ignored when full, pop when empty
`timescale 1ns/1ps
`default_nettype none
module pbd_pnq (
	input wire logic clk, // Clock
	input wire logic nrst, // Async reset, low
	input wire logic push, // Append entry
	input wire logic [4:0] din, // Entry in
	input wire logic pop, // Drop head
	output logic [4:0] head, // Head entry
	output logic empty // No entries
);
	typedef struct packed {
		logic [pbd_pkg::QDEPTH-1:0][4:0] m;
		logic [4:0] rd;
		logic [4:0] wr;
		logic [4:0] n;
	} pbd_q_t;
	pbd_q_t s_q, s_d;

	function automatic logic [4:0] nxt(input logic [4:0] p);
		return (p == 5'(pbd_pkg::QDEPTH - 1)) ? 5'h00 : p + 5'h01;
	endfunction : nxt

	logic doPush, doPop;
	assign doPush = push && (s_q.n != 5'(pbd_pkg::QDEPTH));
	assign doPop = pop && (s_q.n != 5'h00);

	always_comb begin
		s_d = s_q;
		if (doPush) begin
			s_d.m[s_q.wr] = din;
			s_d.wr = nxt(s_q.wr);
		end
		if (doPop) begin
			s_d.rd = nxt(s_q.rd);
		end
		s_d.n = s_q.n + {4'h0, doPush} - {4'h0, doPop};
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign head = s_q.m[s_q.rd];
	assign empty = (s_q.n == 5'h00);

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_q_bound: assert property (s_q.n <= 5'(pbd_pkg::QDEPTH))
		else $error("queue count over depth");
	a_q_first: assert property (empty && push |=> !empty && head == $past(din))
		else $error("queue head not first entry");
endmodule : pbd_pnq
`default_nettype wire

// File: design/pbd_wait.sv
// Purpose: bus ready hold-off timer
// Assumes: start only while idle
// Notes: busy for WAIT_CYC cycles after start
`timescale 1ns/1ps
`default_nettype none
module pbd_wait (
	input wire logic clk, // Clock
	input wire logic nrst, // Async reset, low
	input wire logic start, // Begin hold-off
	output logic busy // Hold-off running
);
	typedef struct packed {
		logic [4:0] cnt;
	} pbd_w_t;
	pbd_w_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (start) begin
			s_d.cnt = pbd_pkg::WAIT_N;
		end else if (s_q.cnt != 5'h00) begin
			s_d.cnt = s_q.cnt - 5'h01;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = (s_q.cnt != 5'h00);

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_wait_len: assert property (start |-> ##10 busy ##1 !busy)
		else $error("hold-off length wrong");
endmodule : pbd_wait
`default_nettype wire

// File: design/pbd_packet_dma.sv
// Purpose: data window, arbiter, DMA and packet number queues
// Assumes: memory answers on the memReq/memAck cycle
// Notes: MAC transfers have priority over host window cycles
// Operation
// - Wait off: drop ready 100-150 ns
// - Zero wait: drop ready only on FIFO
// - Window writes buffered, drained by arbitration
// - Pointer load prefetches, odd gives three bytes
// - Odd write pointer commits lone byte
// - MAC cycles present DMA address, packet
// - Alternate MAC receive and transmit requests
// - Transmit only when running and queued
// - Separate 11-bit transmit and receive counters
// - Allocate on reception, write while data
// - Address miss releases buffer, stops frame
// - Good CRC queues, bad CRC releases unless B_BAD set
// - Auto release skips completion queue for frames sent well
// - Over 1532 bytes aborts and releases
// - Failed allocation: overrun if MAC FIFO fills, flush next frame
// - Count and status into buffer head
// - Retransmit after collision below 16 tries
// - Enqueue command keeps order, drained flag
// - Completion head readable, ack pops
// - Receive queue head, remove commands pop
// - Queues 5-bit wide, 18 deep
// - Any packet number may be enqueued
`timescale 1ns/1ps
`default_nettype none
module pbd_packet_dma (
	input wire logic clk, // Clock
	input wire logic nrst, // Async reset, low
	input wire logic awvalid, // AXI write address
	output logic awready, // AXI
	input wire logic [7:0] awaddr, // AXI
	input wire logic wvalid, // AXI write data
	output logic wready, // AXI
	input wire logic [31:0] wdata, // AXI
	input wire logic [3:0] wstrb, // AXI
	output logic bvalid, // AXI write response
	input wire logic bready, // AXI
	output logic [1:0] bresp, // AXI
	input wire logic arvalid, // AXI read address
	output logic arready, // AXI
	input wire logic [7:0] araddr, // AXI
	output logic rvalid, // AXI read data
	input wire logic rready, // AXI
	output logic [31:0] rdata, // AXI
	output logic [1:0] rresp, // AXI
	output logic busReady, // Bus ready line
	output logic memReq, // Memory request
	input wire logic memAck, // Memory transfer
	output logic memWr, // Write cycle
	output logic memWord, // Word, else byte
	output logic [10:0] memAddr, // Offset in packet
	output logic [4:0] memPkt, // Packet to map
	output logic [15:0] memWdata, // Write data
	input wire logic [15:0] memRdata, // Read data
	output logic allocReq, // Allocation request
	input wire logic allocAck, // Allocation answer
	input wire logic allocOk, // Allocation succeeded
	input wire logic [4:0] allocPkt, // Granted packet
	output logic relReq, // Release pulse
	output logic [4:0] relPkt, // Packet to release
	output logic macTxValid, // Word to MAC
	input wire logic macTxReady, // MAC takes word
	output logic [15:0] macTxData, // Transmit word
	input wire logic macTxDone, // Frame finished
	input wire logic macTxOk, // Finished well
	input wire logic [15:0] macTxStatus, // Status word
	input wire logic macCollide, // Collision pulse
	input wire logic macTxFail, // Clears transmit_run
	input wire logic macRxActive, // Reception active
	input wire logic macRxValid, // Receive word ready
	output logic macRxReady, // Word taken
	input wire logic [15:0] macRxData, // Receive word
	input wire logic macAddrMiss, // Destination mismatch
	input wire logic macRxEnd, // Frame end pulse
	input wire logic macCrcOk, // CRC good
	input wire logic macFifoFull, // MAC FIFO full
	output logic macFlush, // Flush MAC FIFO
	output logic receiveOverrunIrq // Overrun flag
);
	typedef struct packed {
		logic [4:0] ctrl;
		logic [10:0] ptr;
		logic [4:0] pnr;
		logic awH;
		logic [7:0] awA;
		logic wH;
		logic [31:0] wD;
		logic [3:0] wS;
		logic arH;
		logic [7:0] arA;
		logic opW;
		logic opR;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] rf;
		logic [2:0] rfN;
		logic [10:0] fa;
		logic [31:0] wf;
		logic [2:0] wfN;
		logic [10:0] wa;
		logic lastRx;
		pbd_pkg::pbd_tx_t tx;
		logic [4:0] txPkt;
		logic [10:0] txA;
		logic [4:0] txTry;
		logic [15:0] txD;
		logic [15:0] txSt;
		logic txV;
		logic txOk;
		logic colP;
		logic doneP;
		pbd_pkg::pbd_rx_t rx;
		logic [4:0] rxPkt;
		logic [10:0] rxA;
		logic [10:0] rxCnt;
		logic ovPend;
		logic abort;
		logic ovrn;
		logic relReq;
		logic [4:0] relPkt;
		logic flush;
	} pbd_st_t;
	pbd_st_t s_q, s_d;

	// Append k bytes of d at byte position n
	function automatic logic [31:0] put(input logic [31:0] f,
		input logic [2:0] n, input logic [15:0] d, input logic [1:0] k);
		logic [31:0] v;
		v = (k == 2'h2) ? {16'h0000, d} : {24'h00_0000, d[7:0]};
		return f | (v << {n, 3'b000});
	endfunction : put

	function automatic logic mapped(input logic [7:0] a);
		return a == pbd_pkg::A_CTRL || a == pbd_pkg::A_PTR ||
			a == pbd_pkg::A_DATA || a == pbd_pkg::A_PNR ||
			a == pbd_pkg::A_CMD || a == pbd_pkg::A_STAT;
	endfunction : mapped

	// ----------------------------------------
	// Arbiter
	// ----------------------------------------
	logic rxReq, txReq, hwReq, hrReq, selRx, selTx, selHw, selHr, go;
	assign rxReq = (s_q.rx == pbd_pkg::RX_DT && macRxValid) ||
		s_q.rx == pbd_pkg::RX_CN;
	assign txReq = (s_q.tx == pbd_pkg::TX_RD && !s_q.doneP &&
		!s_q.colP) || s_q.tx == pbd_pkg::TX_ST;
	assign hwReq = s_q.wfN != 3'h0;
	assign hrReq = s_q.rfN <= 3'h2;
	assign selRx = rxReq && (!txReq || !s_q.lastRx);
	assign selTx = txReq && !selRx;
	assign selHw = hwReq && !rxReq && !txReq;
	assign selHr = hrReq && !hwReq && !rxReq && !txReq;
	assign memReq = selRx || selTx || selHw || selHr;
	assign go = memReq && memAck;
	assign memWr = selRx || (selTx && s_q.tx == pbd_pkg::TX_ST) || selHw;
	assign memWord = selRx || selTx ||
		(selHw && !s_q.wa[0] && s_q.wfN >= 3'h2) ||
		(selHr && !s_q.fa[0]);
	// MAC cycles carry the DMA address and active packet
	assign memAddr = selRx ? (s_q.rx == pbd_pkg::RX_CN ? pbd_pkg::HDR_OFF :
		s_q.rxA) : selTx ? (s_q.tx == pbd_pkg::TX_ST ? pbd_pkg::HDR_OFF :
		s_q.txA) : selHw ? s_q.wa : s_q.fa;
	assign memPkt = selRx ? s_q.rxPkt : selTx ? s_q.txPkt : s_q.pnr;
	assign memWdata = selRx ? (s_q.rx == pbd_pkg::RX_CN ?
		{5'h00, s_q.rxCnt} : macRxData) : selTx ? s_q.txSt :
		!selHw ? 16'h0000 : s_q.wa[0] ? {s_q.wf[7:0], 8'h00} :
		memWord ? s_q.wf[15:0] : {8'h00, s_q.wf[7:0]};

	// ----------------------------------------
	// Queues and hold-off timer
	// ----------------------------------------
	logic txqPush, txqPop, cqPush, cqPop, rxqPush, rxqPop;
	logic txqE, cqE, rxqE, waitStart, waitBusy;
	logic [4:0] txqHead, cqHead, rxqHead;
	pbd_pnq u_txq (.clk(clk), .nrst(nrst), .push(txqPush), .din(s_q.pnr),
		.pop(txqPop), .head(txqHead), .empty(txqE));
	pbd_pnq u_cq (.clk(clk), .nrst(nrst), .push(cqPush), .din(s_q.txPkt),
		.pop(cqPop), .head(cqHead), .empty(cqE));
	pbd_pnq u_rxq (.clk(clk), .nrst(nrst), .push(rxqPush), .din(s_q.rxPkt),
		.pop(rxqPop), .head(rxqHead), .empty(rxqE));
	pbd_wait u_wait (.clk(clk), .nrst(nrst), .start(waitStart),
		.busy(waitBusy));

	logic stW, stR, wOk, rOk, exW, exR;
	assign stW = !s_q.opW && !s_q.opR && s_q.awH && s_q.wH && !s_q.bvalid;
	assign stR = !s_q.opW && !s_q.opR && !stW && s_q.arH && !s_q.rvalid;
	assign waitStart = (stW || stR) && !s_q.ctrl[pbd_pkg::B_ZW];
	assign wOk = s_q.awA != pbd_pkg::A_DATA || s_q.wfN <= 3'h2;
	assign rOk = s_q.arA != pbd_pkg::A_DATA || s_q.rfN >= 3'h2;
	assign exW = s_q.opW && !waitBusy && wOk;
	assign exR = s_q.opR && !waitBusy && rOk;
	assign busReady = !((s_q.opW && !exW) || (s_q.opR && !exR));

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic [1:0] k;
	logic [2:0] cmd;
	logic hRel;
	always_comb begin
		s_d = s_q;
		k = 2'h0;
		cmd = 3'h0;
		hRel = 1'b0;
		txqPush = 1'b0;
		txqPop = 1'b0;
		cqPush = 1'b0;
		cqPop = 1'b0;
		rxqPush = 1'b0;
		rxqPop = 1'b0;
		s_d.relReq = 1'b0;
		s_d.flush = 1'b0;
		if (go && selRx) s_d.lastRx = 1'b1;
		if (go && selTx) s_d.lastRx = 1'b0;
		// Write-behind drain
		if (go && selHw) begin
			k = memWord ? 2'h2 : 2'h1;
			s_d.wf = s_q.wf >> {k, 3'b000};
			s_d.wfN = s_q.wfN - {1'b0, k};
			s_d.wa = s_q.wa + {9'h000, k};
		end
		// Read-ahead fill
		if (go && selHr) begin
			k = memWord ? 2'h2 : 2'h1;
			s_d.rf = put(s_q.rf, s_q.rfN,
				s_q.fa[0] ? {8'h00, memRdata[15:8]} : memRdata, k);
			s_d.rfN = s_q.rfN + {1'b0, k};
			s_d.fa = s_q.fa + {9'h000, k};
		end
		if (awvalid && !s_q.awH) begin
			s_d.awH = 1'b1;
			s_d.awA = awaddr;
		end
		if (wvalid && !s_q.wH) begin
			s_d.wH = 1'b1;
			s_d.wD = wdata;
			s_d.wS = wstrb;
		end
		if (arvalid && !s_q.arH) begin
			s_d.arH = 1'b1;
			s_d.arA = araddr;
		end
		if (s_q.bvalid && bready) s_d.bvalid = 1'b0;
		if (s_q.rvalid && rready) s_d.rvalid = 1'b0;
		if (stW) s_d.opW = 1'b1;
		if (stR) s_d.opR = 1'b1;
		if (macTxFail) s_d.ctrl[pbd_pkg::B_TXRUN] = 1'b0;
		// Register write
		if (exW) begin
			s_d.opW = 1'b0;
			s_d.awH = 1'b0;
			s_d.wH = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = mapped(s_q.awA) ? 2'h0 : 2'h2;
			if (s_q.wS[0]) begin
				case (s_q.awA)
					pbd_pkg::A_CTRL: s_d.ctrl = s_q.wD[4:0];
					pbd_pkg::A_PTR: begin
						s_d.ptr = s_q.wD[10:0];
						s_d.fa = s_q.wD[10:0];
						s_d.wa = s_q.wD[10:0];
						s_d.rfN = 3'h0;
						s_d.rf = 32'h0000_0000;
						s_d.wfN = 3'h0;
						s_d.wf = 32'h0000_0000;
					end
					pbd_pkg::A_DATA: begin
						k = s_q.wS[1] ? 2'h2 : 2'h1;
						s_d.wf = put(s_d.wf, s_d.wfN, s_q.wD[15:0], k);
						s_d.wfN = s_d.wfN + {1'b0, k};
						s_d.ptr = s_q.ptr + {9'h000, k};
					end
					pbd_pkg::A_PNR: s_d.pnr = s_q.wD[4:0];
					pbd_pkg::A_CMD: cmd = s_q.wD[2:0];
					pbd_pkg::A_STAT: begin
						if (s_q.wD[pbd_pkg::S_ABORT]) s_d.abort = 1'b0;
						if (s_q.wD[pbd_pkg::S_OVRN]) s_d.ovrn = 1'b0;
					end
					default: s_d.bresp = 2'h2;
				endcase
			end
		end
		case (cmd)
			pbd_pkg::C_ENQ: txqPush = 1'b1;
			pbd_pkg::C_TXACK: cqPop = 1'b1;
			pbd_pkg::C_RXRM: rxqPop = 1'b1;
			pbd_pkg::C_RXREL: begin
				rxqPop = 1'b1;
				hRel = !rxqE;
			end
			default: ;
		endcase
		// Register read
		if (exR) begin
			s_d.opR = 1'b0;
			s_d.arH = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rresp = mapped(s_q.arA) ? 2'h0 : 2'h2;
			s_d.rdata = 32'h0000_0000;
			case (s_q.arA)
				pbd_pkg::A_CTRL: s_d.rdata[4:0] = s_q.ctrl;
				pbd_pkg::A_PTR: s_d.rdata[10:0] = s_q.ptr;
				pbd_pkg::A_PNR: s_d.rdata[4:0] = s_q.pnr;
				pbd_pkg::A_DATA: begin
					s_d.rdata[15:0] = s_d.rf[15:0];
					s_d.rf = s_d.rf >> 16;
					s_d.rfN = s_d.rfN - 3'h2;
					s_d.ptr = s_q.ptr + 11'h002;
				end
				pbd_pkg::A_STAT: begin
					s_d.rdata[4:0] = cqHead;
					s_d.rdata[12:8] = rxqHead;
					s_d.rdata[pbd_pkg::S_TXQE] = txqE;
					s_d.rdata[pbd_pkg::S_CQNE] = !cqE;
					s_d.rdata[pbd_pkg::S_RXQE] = rxqE;
					s_d.rdata[pbd_pkg::S_ABORT] = s_q.abort;
					s_d.rdata[pbd_pkg::S_OVRN] = s_q.ovrn;
				end
				default: ;
			endcase
		end
		// Receive DMA
		case (s_q.rx)
			pbd_pkg::RX_IDLE: if (s_q.ctrl[pbd_pkg::B_RXRUN] && macRxActive) begin
				s_d.flush = s_q.ovPend;
				s_d.ovPend = 1'b0;
				s_d.rx = pbd_pkg::RX_AL;
			end
			pbd_pkg::RX_AL: if (allocAck) begin
				if (allocOk) begin
					s_d.rxPkt = allocPkt;
					s_d.rxA = pbd_pkg::DATA_OFF;
					s_d.rxCnt = 11'h000;
					s_d.rx = pbd_pkg::RX_DT;
				end else begin
					s_d.ovPend = 1'b1;
					s_d.rx = pbd_pkg::RX_DR;
				end
			end
			pbd_pkg::RX_DT: begin
				if (go && selRx) begin
					s_d.rxA = s_q.rxA + 11'h002;
					s_d.rxCnt = s_q.rxCnt + 11'h002;
				end
				if (macAddrMiss) begin
					s_d.relReq = 1'b1;
					s_d.rx = pbd_pkg::RX_DR;
				end else if (s_q.rxCnt > pbd_pkg::MAX_FRAME) begin
					s_d.abort = 1'b1;
					s_d.relReq = 1'b1;
					s_d.rx = pbd_pkg::RX_DR;
				end else if (macRxEnd) begin
					if (macCrcOk || s_q.ctrl[pbd_pkg::B_BAD]) begin
						s_d.rx = pbd_pkg::RX_CN;
					end else begin
						s_d.relReq = 1'b1;
						s_d.rx = pbd_pkg::RX_DR;
					end
				end
				s_d.relPkt = s_q.rxPkt;
			end
			pbd_pkg::RX_CN: if (go && selRx) begin
				rxqPush = 1'b1;
				s_d.rx = pbd_pkg::RX_DR;
			end
			pbd_pkg::RX_DR: begin
				if (s_q.ovPend && macFifoFull) s_d.ovrn = 1'b1;
				if (!macRxActive) s_d.rx = pbd_pkg::RX_IDLE;
			end
			default: s_d.rx = pbd_pkg::RX_IDLE;
		endcase
		// Transmit DMA
		if (macTxDone) begin
			s_d.doneP = 1'b1;
			s_d.txOk = macTxOk;
			s_d.txSt = macTxStatus;
		end
		if (macCollide) s_d.colP = 1'b1;
		case (s_q.tx)
			pbd_pkg::TX_IDLE: begin
				s_d.doneP = 1'b0;
				s_d.colP = 1'b0;
				if (s_q.ctrl[pbd_pkg::B_TXRUN] && !txqE) begin
					s_d.txPkt = txqHead;
					s_d.txA = pbd_pkg::DATA_OFF;
					s_d.txTry = 5'h00;
					s_d.tx = pbd_pkg::TX_RD;
				end
			end
			pbd_pkg::TX_RD, pbd_pkg::TX_SND: begin
				if (s_q.doneP) begin
					s_d.doneP = 1'b0;
					s_d.txV = 1'b0;
					s_d.tx = pbd_pkg::TX_ST;
				end else if (s_q.colP) begin
					s_d.colP = 1'b0;
					s_d.txV = 1'b0;
					if (s_q.txTry < pbd_pkg::TRY_LAST) begin
						s_d.txTry = s_q.txTry + 5'h01;
						s_d.txA = pbd_pkg::DATA_OFF;
						s_d.tx = pbd_pkg::TX_RD;
					end else begin
						s_d.txOk = 1'b0;
						s_d.tx = pbd_pkg::TX_ST;
					end
				end else if (s_q.tx == pbd_pkg::TX_RD) begin
					if (go && selTx) begin
						s_d.txD = memRdata;
						s_d.txV = 1'b1;
						s_d.tx = pbd_pkg::TX_SND;
					end
				end else if (macTxReady) begin
					s_d.txV = 1'b0;
					s_d.txA = s_q.txA + 11'h002;
					s_d.tx = pbd_pkg::TX_RD;
				end
			end
			pbd_pkg::TX_ST: if (go && selTx) s_d.tx = pbd_pkg::TX_FN;
			pbd_pkg::TX_FN: if (!s_d.relReq) begin
				txqPop = 1'b1;
				if (s_q.ctrl[pbd_pkg::B_AREL] && s_q.txOk) begin
					s_d.relReq = 1'b1;
					s_d.relPkt = s_q.txPkt;
				end else begin
					cqPush = 1'b1;
				end
				s_d.tx = pbd_pkg::TX_IDLE;
			end
			default: s_d.tx = pbd_pkg::TX_IDLE;
		endcase
		if (hRel && !s_d.relReq) begin
			s_d.relReq = 1'b1;
			s_d.relPkt = rxqHead;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.ctrl <= pbd_pkg::CTRL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign awready = !s_q.awH;
	assign wready = !s_q.wH;
	assign arready = !s_q.arH;
	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign rvalid = s_q.rvalid;
	assign rdata = s_q.rdata;
	assign rresp = s_q.rresp;
	assign allocReq = s_q.rx == pbd_pkg::RX_AL;
	assign relReq = s_q.relReq;
	assign relPkt = s_q.relPkt;
	assign macTxValid = s_q.txV;
	assign macTxData = s_q.txD;
	assign macRxReady = go && selRx && s_q.rx == pbd_pkg::RX_DT;
	assign macFlush = s_q.flush;
	assign receiveOverrunIrq = s_q.ovrn;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_wait_ready: assert property (waitStart |=> !busReady [*8])
		else $error("ready not held low");
	a_zw_ready: assert property (s_q.ctrl[pbd_pkg::B_ZW] && s_q.opW && wOk |-> busReady)
		else $error("needless wait state");
	a_wr_drain: assert property (hwReq && !rxReq && !txReq |-> memReq && memWr)
		else $error("write-behind not requested");
	a_odd_byte: assert property (selHw && s_q.wa[0] |-> !memWord)
		else $error("odd write not a byte");
	a_mac_pkt: assert property (selTx |-> memPkt == s_q.txPkt)
		else $error("wrong packet on MAC cycle");
	a_mac_alt: assert property (go && selRx ##1 rxReq && txReq |-> selTx)
		else $error("MAC requests not alternated");
	a_tx_start: assert property (s_q.tx == pbd_pkg::TX_IDLE && s_d.tx == pbd_pkg::TX_RD |-> s_q.ctrl[pbd_pkg::B_TXRUN] && !txqE)
		else $error("transmit without run or queue");
	a_rx_miss: assert property (s_q.rx == pbd_pkg::RX_DT && macAddrMiss |=> relReq && relPkt == $past(s_q.rxPkt))
		else $error("missed frame not released");
	a_rx_long: assert property (s_q.rx == pbd_pkg::RX_DT && !macAddrMiss && s_q.rxCnt > pbd_pkg::MAX_FRAME |=> s_q.abort && relReq)
		else $error("long frame not aborted");
	c_rx_frame: cover property (rxqPush);
	c_tx_auto: cover property (s_q.tx == pbd_pkg::TX_FN && txqPop && !cqPush);
	c_retry: cover property (s_q.colP && s_q.txTry != 5'h00);
	c_overrun: cover property (receiveOverrunIrq);
endmodule : pbd_packet_dma
`default_nettype wire

// File: dv/pbd_far_model.sv
// Purpose: buffer memory, allocator and MAC transmit side
// Assumes: one flat byte space shared by all packets
// Notes: jit slows memory and MAC answers at random
`timescale 1ns/1ps
`default_nettype none
module pbd_far_model (
	input wire logic clk, // Clock
	input wire logic nrst, // Reset, low
	input wire logic jit, // Answer now
	input wire logic memReq, // Request
	input wire logic memWr, // Write
	input wire logic memWord, // Word
	input wire logic [10:0] memAddr, // Offset
	input wire logic [15:0] memWdata, // Data in
	output logic memAck, // Taken
	output logic [15:0] memRdata, // Data out
	input wire logic allocReq, // Allocate
	output logic allocAck, // Granted
	input wire logic macTxValid, // Word offered
	output logic macTxReady, // Word taken
	output logic macTxDone // Frame end
);
	logic [7:0] mem [2048];
	logic [10:0] b;
	logic [1:0] n;
	assign b = {memAddr[10:1], 1'b0};
	assign memAck = memReq & jit;
	// Released bus shows inverted data
	assign memRdata = {mem[b + 1], mem[b]} ^ {16{!memReq}};
	assign macTxReady = macTxValid & jit & !macTxDone;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			allocAck <= 0;
			macTxDone <= 0;
			n <= 0;
		end else begin
			allocAck <= allocReq & !allocAck;
			macTxDone <= 0;
			if (macTxReady) n <= n + 2'd1;
			if (n == 2) begin
				macTxDone <= 1;
				n <= 0;
			end
			if (memAck & memWr & memWord) begin
				mem[b] <= memWdata[7:0];
				mem[b + 1] <= memWdata[15:8];
			end else if (memAck & memWr)
				mem[memAddr] <= memAddr[0] ? memWdata[15:8] : memWdata[7:0];
		end
	end
endmodule : pbd_far_model
`default_nettype wire

// File: dv/pbd_packet_dma_tb_top.sv
// Purpose: self-checking bench for the packet buffer DMA
// Assumes: AXI4-Lite master tasks, model on the far side
// Notes: seeded random packet numbers, data and stalls
`timescale 1ns/1ps
`default_nettype none
module pbd_packet_dma_tb_top;
	logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, jit, t;
	logic awready, wready, bvalid, arready, rvalid, busReady, memReq, memAck;
	logic memWr, memWord, allocReq, allocAck, relReq, macTxValid, macTxReady;
	logic macTxDone, macRxReady, macFlush, receiveOverrunIrq, macRxActive;
	logic macRxValid, macRxEnd, macCrcOk;
	logic macAddrMiss = 0, macFifoFull = 0, macCollide = 0, macTxFail = 0;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, r;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [10:0] memAddr;
	logic [4:0] memPkt, relPkt, pktIn, p1, p2;
	logic [15:0] memWdata, memRdata, macTxData, macRxData, txStat, w0;
	integer seed = 32'hdb39b820, bad_count = 0, comparisons = 0, lowTot = 0, d0;
	pbd_packet_dma pbd_packet_dma_inst (.clk, .nrst, .awvalid, .awready, .awaddr,
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .rvalid, .rready, .rdata, .rresp, .busReady, .memReq,
		.memAck, .memWr, .memWord, .memAddr, .memPkt, .memWdata, .memRdata,
		.allocReq, .allocAck, .allocOk(allocAck), .allocPkt(pktIn), .relReq,
		.relPkt, .macTxValid, .macTxReady, .macTxData, .macTxDone,
		.macTxOk(macTxDone), .macTxStatus(txStat), .macCollide, .macTxFail,
		.macRxActive, .macRxValid, .macRxReady, .macRxData, .macAddrMiss,
		.macRxEnd, .macCrcOk, .macFifoFull, .macFlush, .receiveOverrunIrq);
	pbd_far_model pbd_far_model_inst (.clk, .nrst, .jit, .memReq, .memWr,
		.memWord, .memAddr, .memWdata, .memAck, .memRdata, .allocReq, .allocAck,
		.macTxValid, .macTxReady, .macTxDone);
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		jit <= 1'($random(seed));
		txStat <= 16'($random(seed));
		if (nrst && busReady === 0) lowTot <= lowTot + 1;
	end
	function logic [4:0] rnd();
		rnd = 5'($unsigned($random(seed)) % 18);
	endfunction : rnd
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic ra, rw, rb;
		logic [1:0] rs;
		@(posedge clk);
		rb = 0;
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		while (rb !== 1) begin
			@(negedge clk);
			ra = awready; rw = wready; rb = bvalid; rs = bresp;
			@(posedge clk);
			if (ra) awvalid <= 0;
			if (rw) wvalid <= 0;
		end
		bready <= 0;
		chk(rs, e);
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d);
		logic ra, rb;
		@(posedge clk);
		rb = 0;
		araddr <= a; arvalid <= 1; rready <= 1;
		while (rb !== 1) begin
			@(negedge clk);
			ra = arready; rb = rvalid; d = rdata;
			@(posedge clk);
			if (ra) arvalid <= 0;
		end
		rready <= 0;
	endtask : rd
	task end_sim;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	initial begin
		#400000;
		bad_count++;
		end_sim();
	end
	initial begin
		nrst = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
		awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hF;
		pktIn = 0; macRxActive = 0; macRxValid = 0; macRxEnd = 0; macCrcOk = 0;
		macRxData = 0;
		repeat (3) @(posedge clk);
		nrst <= 1;
		rd(pbd_pkg::A_STAT, r);
		chk(r[18:16], 3'b101);
		wr(8'h3C, 0, 2'b10);
		wr(pbd_pkg::A_CTRL, 0, 0);
		d0 = lowTot;
		rd(pbd_pkg::A_CTRL, r);
		chk((lowTot - d0) >= 10 && (lowTot - d0) <= 15, 1);
		wr(pbd_pkg::A_CTRL, 1, 0);
		d0 = lowTot;
		rd(pbd_pkg::A_CTRL, r);
		chk(lowTot == d0, 1);
		$display("hold-off test done");
		// Odd pointer: lone byte, then a word
		wr(pbd_pkg::A_PTR, 32'h0000_0101, 0);
		wr(pbd_pkg::A_DATA, 32'h0000_BEEF, 0);
		wr(pbd_pkg::A_DATA, 32'h0000_1234, 0);
		repeat (40) @(posedge clk);
		chk({pbd_far_model_inst.mem[258], pbd_far_model_inst.mem[257]}, 16'hBEEF);
		wr(pbd_pkg::A_PTR, 32'h0000_0101, 0);
		rd(pbd_pkg::A_DATA, r);
		chk(r[15:0], 16'hBEEF);
		$display("window test done");
		p1 = rnd();
		p2 = rnd();
		wr(pbd_pkg::A_PNR, 32'(p1), 0);
		wr(pbd_pkg::A_CMD, 32'(pbd_pkg::C_ENQ), 0);
		wr(pbd_pkg::A_PNR, 32'(p2), 0);
		wr(pbd_pkg::A_CMD, 32'(pbd_pkg::C_ENQ), 0);
		rd(pbd_pkg::A_STAT, r);
		chk(r[17:16], 2'b00);
		wr(pbd_pkg::A_CTRL, 32'h0000_0003, 0);
		do rd(pbd_pkg::A_STAT, r); while (r[16] !== 1);
		rd(pbd_pkg::A_STAT, r);
		chk({r[17], r[4:0]}, {1'b1, p1});
		wr(pbd_pkg::A_CMD, 32'(pbd_pkg::C_TXACK), 0);
		rd(pbd_pkg::A_STAT, r);
		chk(r[4:0], p2);
		wr(pbd_pkg::A_CMD, 32'(pbd_pkg::C_TXACK), 0);
		rd(pbd_pkg::A_STAT, r);
		chk(r[17:16], 2'b01);
		$display("transmit test done");
		wr(pbd_pkg::A_CTRL, 32'h0000_0005, 0);
		p1 = rnd();
		pktIn <= p1;
		macRxActive <= 1;
		for (int i = 0; i < 2; i++) begin
			macRxData <= 16'($random(seed));
			macRxValid <= 1;
			do begin
				@(negedge clk);
				t = macRxReady;
				if (i == 0) w0 = macRxData;
				@(posedge clk);
			end while (t !== 1);
		end
		macRxValid <= 0; macRxEnd <= 1; macCrcOk <= 1;
		@(posedge clk);
		macRxEnd <= 0; macRxActive <= 0;
		do rd(pbd_pkg::A_STAT, r); while (r[18] !== 0);
		chk(r[12:8], p1);
		chk({pbd_far_model_inst.mem[3], pbd_far_model_inst.mem[2]}, w0);
		chk({pbd_far_model_inst.mem[1], pbd_far_model_inst.mem[0]}, 4);
		wr(pbd_pkg::A_CMD, 32'(pbd_pkg::C_RXRM), 0);
		rd(pbd_pkg::A_STAT, r);
		chk(r[18], 1);
		// Address miss: one release of the granted buffer
		p2 = rnd();
		pktIn <= p2;
		macRxActive <= 1;
		macAddrMiss <= 1;
		d0 = 0;
		repeat (8) begin
			@(negedge clk);
			if (relReq === 1) begin
				d0++;
				chk(relPkt, p2);
			end
		end
		chk(d0, 1);
		@(posedge clk);
		macAddrMiss <= 0; macRxActive <= 0;
		$display("receive test done");
		end_sim();
	end
endmodule : pbd_packet_dma_tb_top
`default_nettype wire
